/* shared/stc_pkg.sv */
// Package for the self-test command handler: codes, fields, bus map
package stc_pkg;
    localparam logic [3:0] CMD_DISABLE_ST = 4'hC;
    localparam logic [3:0] CMD_ENABLE_ST  = 4'hD;
    localparam logic [3:0] CMD_UNIMPL_14  = 4'hE;
    localparam logic [3:0] ADDR_GLOBAL    = 4'h0;
    // Command word fields: data[15:8], address[7:4], command[3:0]
    localparam int CMD_CODE_LSB  = 0;
    localparam int CMD_ADDR_LSB  = 4;
    localparam int CMD_DATA_LSB  = 8;
    // Response flag positions in the low byte, and the address field LSB
    localparam int RSP_ERR_BIT   = 1;
    localparam int RSP_ATTR_LSB  = 2;
    localparam int RSP_BSW_BIT   = 4;
    localparam int RSP_ST_BIT    = 5;
    localparam int RSP_HOLD_CAPACITOR_NODE_BIT  = 6;
    localparam int RSP_OTP_BIT   = 7;
    localparam int RSP_ADDR_LSB  = 12;
    // Wishbone register byte offsets
    localparam logic [3:0] OFF_CONFIG = 4'h0;
    localparam logic [3:0] OFF_STATUS = 4'h4;
    localparam logic [3:0] OFF_RESP   = 4'h8;
    // Config register fields
    localparam int CFG_ADDR_LSB  = 0;
    localparam int CFG_ATTR_LSB  = 4;
    localparam int CFG_BSW_BIT   = 6;
    localparam int CFG_OTP_BIT   = 7;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [1:0] DIS_COUNT_LOCK = 2'h2;
endpackage

/* rtl/stc_sync3.sv */
// Three-stage synchroniser with agreement filter for one level input
`timescale 1ns/1ps
module stc_sync3 (
    input  wire logic i_clk,
    input  wire logic i_srst,
    input  wire logic i_async,
    output logic      o_level
);
    logic [2:0] sh_reg;
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            sh_reg  <= 3'h0;
            o_level <= 1'b0;
        end else begin
            sh_reg <= {sh_reg[1:0], i_async};
            if (sh_reg[1] == sh_reg[2]) begin
                o_level <= sh_reg[2];
            end
        end
    end
endmodule

/* rtl/stc_selftest_cmd.sv */
// Self-test command handler: decode, lockout, response build, Wishbone regs
// Functional notes
// R1: Short response has bits 14:8 zero, flags in 7:1, bit 0 zero.
// R2: Long response carries address in 15:12, zeros 11:8, same low byte.
// R3: Error flag reads 1 when an internal error is detected, else 0.
// R4: Attribute bits are copied from the first configuration register.
// R5: Bus switch bit reflects switch control, 1 means close the switch.
// R6: Self-test flag is 1 while stimulus applied, 0 when disabled.
// R7: Hold capacitor flag set while the monitor reports undervoltage.
// R8: OTP enable flag reads 1 when user OTP programming is enabled.
// R9: Two consecutive disable commands engage the self-test lockout.
// R10: Lockout holds self-test off until undervoltage, clear or resets.
// R11: Enable command accepted in both short and long formats.
// R12: Enable command code is 1101.
// R13: Enable command to global address 0000 is ignored.
// R14: Command data byte only feeds the CRC check, nothing else.
// R15: Command acted on only when its address matches device address; the code also acts on a disable to the global address.
// R16: Accepted enable applies stimulus until a disable arrives.
// R17: Enable under lockout leaves self-test off and flag cleared.
// R18: Enable responses use the same layout as disable responses.
// R19: Frames with command code 1110 are ignored.
// R20: Disable command code is 1100.
// R21: Disable to global address acts but sends no response.
// R22: Accepted disable removes the self-test stimulus.
// R23: Any other accepted command resets the consecutive disable count.
`timescale 1ns/1ps
module stc_selftest_cmd (
    input  wire logic        I_CORE_CLK,
    input  wire logic        I_SRST,
    // Frame layer: one-cycle strobe with a CRC-checked command word
    input  wire logic        I_CMD_VALID,
    input  wire logic [15:0] I_CMD_WORD,
    input  wire logic        I_CMD_LONG,
    input  wire logic        I_OTHER_CMD_ACCEPTED,
    input  wire logic        I_CLEAR_CMD,
    input  wire logic        I_INTERNAL_ERROR,
    input  wire logic        I_HOLD_CAPACITOR_NODE_UNDERVOLTAGE,
    // Wishbone classic slave
    input  wire logic        I_WB_CYC,
    input  wire logic        I_WB_STB,
    input  wire logic        I_WB_WE,
    input  wire logic [3:0]  I_WB_ADR,
    input  wire logic [3:0]  I_WB_SEL,
    input  wire logic [31:0] I_WB_DAT,
    output logic [31:0]      O_WB_DAT,
    output logic             O_WB_ACK,
    // Response and stimulus
    output logic             O_RSP_VALID,
    output logic [15:0]      O_RSP_WORD,
    output logic             O_RSP_LONG,
    output logic             O_SELFTEST_STIMULUS,
    output logic             O_BUS_SWITCH_CLOSE
);
    import stc_pkg::*;

    logic       hold_capacitor_node_uv;
    logic [7:0] cfg_reg;
    logic       st_reg;
    logic       lock_reg;
    logic [1:0] dis_cnt_reg;
    logic [1:0] dis_cnt_next;
    logic       st_next;
    logic       lock_next;

    // The undervoltage monitor is analogue and asynchronous to the core
    stc_sync3 u_hold_capacitor_node_sync (
        .i_clk   (I_CORE_CLK),
        .i_srst  (I_SRST),
        .i_async (I_HOLD_CAPACITOR_NODE_UNDERVOLTAGE),
        .o_level (hold_capacitor_node_uv)
    );

    // Command decode; the data byte is deliberately unused (CRC only)
    wire [3:0] cmd_code = I_CMD_WORD[CMD_CODE_LSB +: 4];
    wire [3:0] cmd_addr = I_CMD_WORD[CMD_ADDR_LSB +: 4];
    wire [3:0] dev_addr = cfg_reg[CFG_ADDR_LSB +: 4];
    wire       addr_hit = (cmd_addr == dev_addr); // R15
    wire       is_glob  = (cmd_addr == ADDR_GLOBAL);
    wire       is_en    = (cmd_code == CMD_ENABLE_ST); // R12
    wire       is_dis   = (cmd_code == CMD_DISABLE_ST); // R20
    wire       is_unimp = (cmd_code == CMD_UNIMPL_14); // R19
    // Both formats decode identically; I_CMD_LONG only sizes the reply
    wire       en_acc   = I_CMD_VALID && is_en && addr_hit && !is_glob
                          && !is_unimp; // R11 R13 R14
    wire       dis_acc  = I_CMD_VALID && is_dis && (addr_hit || is_glob);
    wire       dis_rsp  = dis_acc && !is_glob; // R21
    wire       lock_end = hold_capacitor_node_uv || I_CLEAR_CMD; // R10

    // Disable count; another accepted command breaks the run
    // Count from the cleared value, so a clear beside a disable counts one
    always_comb begin
        dis_cnt_next = dis_cnt_reg;
        if (lock_end || en_acc || I_OTHER_CMD_ACCEPTED) begin
            dis_cnt_next = 2'h0; // R23
        end
        if (dis_acc && dis_cnt_next != DIS_COUNT_LOCK) begin
            dis_cnt_next = dis_cnt_next + 2'h1;
        end
    end

    always_comb begin
        lock_next = lock_reg;
        if (dis_cnt_next == DIS_COUNT_LOCK) begin
            lock_next = 1'b1; // R9
        end
        if (lock_end) begin
            lock_next = 1'b0; // R10
        end
    end

    always_comb begin
        st_next = st_reg;
        if (en_acc && !lock_reg) begin
            st_next = 1'b1; // R16
        end
        if (dis_acc || lock_next) begin
            st_next = 1'b0; // R22 R17
        end
    end

    // Response low byte, shared by both commands and both forms
    wire [7:0] rsp_low = {
        cfg_reg[CFG_OTP_BIT],          // R8
        hold_capacitor_node_uv,                       // R7
        st_next,                       // R6
        cfg_reg[CFG_BSW_BIT],          // R5
        cfg_reg[CFG_ATTR_LSB +: 2],    // R4
        I_INTERNAL_ERROR,              // R3
        1'b0
    };
    wire [15:0] rsp_short = {8'h00, rsp_low}; // R1 R18
    wire [15:0] rsp_long  = {dev_addr, 4'h0, rsp_low}; // R2 R18
    wire        rsp_fire  = en_acc || dis_rsp;

    always_ff @(posedge I_CORE_CLK) begin
        if (I_SRST) begin
            st_reg      <= 1'b0;
            lock_reg    <= 1'b0;
            dis_cnt_reg <= 2'h0;
        end else begin
            st_reg      <= st_next;
            lock_reg    <= lock_next;
            dis_cnt_reg <= dis_cnt_next;
        end
    end

    always_ff @(posedge I_CORE_CLK) begin
        if (I_SRST) begin
            O_RSP_VALID <= 1'b0;
            O_RSP_WORD  <= 16'h0000;
            O_RSP_LONG  <= 1'b0;
        end else begin
            O_RSP_VALID <= rsp_fire;
            if (rsp_fire) begin
                O_RSP_WORD <= I_CMD_LONG ? rsp_long : rsp_short;
                O_RSP_LONG <= I_CMD_LONG;
            end
        end
    end

    always_ff @(posedge I_CORE_CLK) begin
        if (I_SRST) begin
            O_SELFTEST_STIMULUS <= 1'b0;
            O_BUS_SWITCH_CLOSE  <= 1'b0;
        end else begin
            O_SELFTEST_STIMULUS <= st_next; // R16
            O_BUS_SWITCH_CLOSE  <= cfg_reg[CFG_BSW_BIT]; // R5
        end
    end

    // Wishbone: one wait-free answer a cycle after the strobe
    wire        wb_req  = I_WB_CYC && I_WB_STB && !O_WB_ACK;
    wire        wb_wcfg = wb_req && I_WB_WE && I_WB_SEL[0]
                          && (I_WB_ADR == OFF_CONFIG);
    wire [31:0] status_word = {28'h0, lock_reg, st_reg, hold_capacitor_node_uv,
                               I_INTERNAL_ERROR};
    wire [31:0] rd_mux = (I_WB_ADR == OFF_CONFIG) ? {24'h0, cfg_reg} :
                         (I_WB_ADR == OFF_STATUS) ? status_word :
                         (I_WB_ADR == OFF_RESP)   ? {16'h0, O_RSP_WORD} :
                         32'h0000_0000;

    always_ff @(posedge I_CORE_CLK) begin
        if (I_SRST) begin
            cfg_reg <= CFG_RESET;
        end else if (wb_wcfg) begin
            cfg_reg <= I_WB_DAT[7:0];
        end
    end

    always_ff @(posedge I_CORE_CLK) begin
        if (I_SRST) begin
            O_WB_ACK <= 1'b0;
            O_WB_DAT <= 32'h0000_0000;
        end else begin
            O_WB_ACK <= wb_req;
            if (wb_req && !I_WB_WE) begin
                O_WB_DAT <= rd_mux;
            end
        end
    end
endmodule

/* testbench/stc_selftest_cmd_assertions.sv */
// Checker for response layout and command decode
`timescale 1ns/1ps
module stc_assertions (
    input wire logic        I_CORE_CLK,
    input wire logic        I_SRST,
    input wire logic        I_CMD_VALID,
    input wire logic [15:0] I_CMD_WORD,
    input wire logic        I_INTERNAL_ERROR,
    input wire logic        O_RSP_VALID,
    input wire logic [15:0] O_RSP_WORD,
    input wire logic        O_RSP_LONG,
    input wire logic        O_SELFTEST_STIMULUS,
    input wire logic        O_BUS_SWITCH_CLOSE
);
    default clocking @(posedge I_CORE_CLK); endclocking
    default disable iff (I_SRST);
    wire logic [3:0] cd = I_CMD_WORD[3:0];
    sequence rsp_s; O_RSP_VALID; endsequence
    sequence glob_s(c); I_CMD_VALID && I_CMD_WORD[7:4] == 4'h0 && cd == c;
    endsequence
    short_fmt_a: assert property (rsp_s ##0 !O_RSP_LONG |->
        O_RSP_WORD[15:8] == 8'h00 && !O_RSP_WORD[0])
        else $error("short layout");
    long_fmt_a: assert property (rsp_s ##0 O_RSP_LONG |->
        O_RSP_WORD[11:8] == 4'h0 && !O_RSP_WORD[0])
        else $error("long layout");
    err_bit_a: assert property (rsp_s |->
        O_RSP_WORD[1] == $past(I_INTERNAL_ERROR)) else $error("error bit");
    bsw_bit_a: assert property (rsp_s |->
        O_RSP_WORD[4] == O_BUS_SWITCH_CLOSE) else $error("switch bit");
    st_bit_a: assert property (rsp_s |->
        O_RSP_WORD[5] == O_SELFTEST_STIMULUS) else $error("self-test bit");
    glob_en_a: assert property (glob_s(4'hD) |=> !O_RSP_VALID)
        else $error("global enable answered");
    glob_dis_a: assert property (glob_s(4'hC) |=>
        !O_RSP_VALID && !O_SELFTEST_STIMULUS) else $error("global disable");
    unimpl_a: assert property (I_CMD_VALID && cd == 4'hE |=>
        !O_RSP_VALID) else $error("code 14 answered");
    rsp_cause_a: assert property (rsp_s |-> $past(I_CMD_VALID) &&
        $past(cd) inside {4'hC, 4'hD}) else $error("response without cause");
endmodule

/* testbench/stc_master_model.sv */
// Bus master model: sends one command word per call
`timescale 1ns/1ps
module stc_master_model (
    input  wire logic   i_clk,
    output logic        o_valid,
    output logic [15:0] o_word,
    output logic        o_long
);
    initial begin
        o_valid = 1'b0;
        o_word  = 16'h0000;
        o_long  = 1'b0;
    end
    // Idle word is inverted so a stale command never looks valid
    task automatic send(input logic [3:0] c, a, input logic l);
        @(posedge i_clk);
        o_valid <= 1'b1;
        o_word  <= {a ^ 4'h9, c ^ 4'h6, a, c};
        o_long  <= l;
        @(posedge i_clk);
        o_valid <= 1'b0;
        o_word  <= ~o_word;
    endtask
endmodule

/* testbench/tb.sv */
// Testbench for the self-test command handler
`timescale 1ns/1ps
module tb;
    import stc_pkg::*;
    logic        clk = 1'b0, srst = 1'b1, oth = 1'b0, clr = 1'b0;
    logic        err = 1'b0, uv = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [3:0]  adr = 4'h0;
    logic [31:0] wd = 32'h0, rd, q;
    logic        cv, cl, rv, rl, st, bs, ack;
    logic [15:0] cw, rw;
    int          n_fail = 0, n_checks = 0;
    always #25 clk = ~clk;
    stc_master_model stc_master_model_i (.i_clk(clk), .o_valid(cv),
        .o_word(cw), .o_long(cl));
    stc_selftest_cmd stc_selftest_cmd_i (.I_CORE_CLK(clk), .I_SRST(srst),
        .I_CMD_VALID(cv), .I_CMD_WORD(cw), .I_CMD_LONG(cl),
        .I_OTHER_CMD_ACCEPTED(oth), .I_CLEAR_CMD(clr),
        .I_INTERNAL_ERROR(err), .I_HOLD_CAPACITOR_NODE_UNDERVOLTAGE(uv), .I_WB_CYC(cyc),
        .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(4'hF),
        .I_WB_DAT(wd), .O_WB_DAT(rd), .O_WB_ACK(ack), .O_RSP_VALID(rv),
        .O_RSP_WORD(rw), .O_RSP_LONG(rl), .O_SELFTEST_STIMULUS(st),
        .O_BUS_SWITCH_CLOSE(bs));
    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string s, input logic [31:0] e, g);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic wb(input logic w, input logic [3:0] a, input int d);
        int i = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        wd  <= d;
        do @(posedge clk); while (ack !== 1'b1 && ++i < 20);
        q = rd;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (i >= 20) begin
            n_fail++;
            conclude;
        end
    endtask
    // Flags for config F5: OTP on, switch closed, attribute 3, address 5
    function automatic logic [7:0] lo(input logic s, u, e);
        return {1'b1, u, s, 1'b1, 2'b11, e, 1'b0};
    endfunction
    task automatic cmd(input logic [3:0] c, a, input logic l, v,
                       input logic [15:0] e);
        stc_master_model_i.send(c, a, l);
        #1;
        chk("rsp_valid", v, rv);
        if (v) chk("rsp_word", e, rw);
        if (v) chk("rsp_long", l, rl);
    endtask
    // Selects the clear strobe when set, else the other-command strobe
    task automatic pulse(input logic sel);
        @(posedge clk);
        if (sel) clr <= 1'b1;
        else oth <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        oth <= 1'b0;
    endtask
    task automatic t_regs;
        wb(0, OFF_CONFIG, 0);
        chk("cfg_reset", CFG_RESET, q);
        cmd(CMD_DISABLE_ST, ADDR_GLOBAL, 0, 0, 0);
        cmd(CMD_ENABLE_ST, ADDR_GLOBAL, 1, 0, 0);
        wb(1, OFF_CONFIG, 32'hF5);
        wb(0, OFF_CONFIG, 0);
        chk("cfg", 32'hF5, q);
        wb(0, 4'hC, 0);
        chk("unmapped", 0, q);
        chk("bus_switch", 1, bs);
    endtask
    task automatic t_enable;
        cmd(CMD_ENABLE_ST, 4'h5, 1, 1, {8'h50, lo(1, 0, 0)});
        cmd(CMD_ENABLE_ST, 4'h5, 0, 1, {8'h00, lo(1, 0, 0)});
        cmd(CMD_DISABLE_ST, 4'h3, 0, 0, 0);
        cmd(CMD_UNIMPL_14, 4'h5, 1, 0, 0);
        chk("stimulus", 1, st);
    endtask
    task automatic t_lock;
        err <= 1'b1;
        cmd(CMD_DISABLE_ST, 4'h5, 1, 1, {8'h50, lo(0, 0, 1)});
        cmd(CMD_DISABLE_ST, 4'h5, 0, 1, {8'h00, lo(0, 0, 1)});
        cmd(CMD_ENABLE_ST, 4'h5, 0, 1, {8'h00, lo(0, 0, 1)});
        pulse(1'b1);
        cmd(CMD_ENABLE_ST, 4'h5, 0, 1, {8'h00, lo(1, 0, 1)});
        cmd(CMD_DISABLE_ST, 4'h5, 0, 1, {8'h00, lo(0, 0, 1)});
        pulse(1'b0);
        cmd(CMD_DISABLE_ST, 4'h5, 0, 1, {8'h00, lo(0, 0, 1)});
        cmd(CMD_ENABLE_ST, 4'h5, 0, 1, {8'h00, lo(1, 0, 1)});
        cmd(CMD_DISABLE_ST, 4'h5, 0, 1, {8'h00, lo(0, 0, 1)});
        cmd(CMD_DISABLE_ST, 4'h5, 0, 1, {8'h00, lo(0, 0, 1)});
        uv <= 1'b1;
        repeat (6) @(posedge clk);
        cmd(CMD_ENABLE_ST, 4'h5, 0, 1, {8'h00, lo(1, 1, 1)});
    endtask
    initial begin
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        t_regs;
        t_enable;
        t_lock;
        conclude;
    end
endmodule
bind stc_selftest_cmd stc_assertions stc_assertions_i (.*);
